// ---- audio_port_cfg.svh ----
`ifndef AUDIO_PORT_CFG_SVH
`define AUDIO_PORT_CFG_SVH

// Register offsets
`define CHAN_FOUR_SLOT_CODE_OFS        8'h0E
`define CFG_A_OFS           8'h13
`define CFG_B_OFS           8'h14
`define CLK_BASIS_OFS       8'h16
`define PORT_STATUS_OFS     8'h17

// Reset values
`define CHAN_FOUR_SLOT_CODE_RST        6'h03
`define CFG_A_RST           8'h02
`define CFG_B_RST           8'h48
`define CLK_BASIS_RST       1'b0

// Field positions in configuration register a
`define ROLE_BIT            7
`define AUTO_BIT            6
`define PLL_OFF_BIT         5
`define GATE_BIT            4
`define FAMILY_BIT          3
`define REF_CODE_MSB        2
`define REF_CODE_LSB        0

// Field positions in configuration register b
`define RATE_MSB            7
`define RATE_LSB            4
`define RATIO_MSB           3
`define RATIO_LSB           0

// Field position in the clock basis register
`define BASIS_BIT           6

// Highest legal codes
`define RATE_CODE_MAX       4'h8
`define RATIO_CODE_MAX      4'hC

// Timing
`define CLK_PERIOD_NS       4
`define BCLK_HALF_NS        32
`define BCLK_HALF_CYC       ((`BCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- audio_port_pkg.sv ----
package audio_port_pkg;

    typedef enum logic [1:0] {
        LINK_IDLE   = 2'b00,
        LINK_MASTER = 2'b01,
        LINK_SLAVE  = 2'b10
    } link_state_t;

    typedef struct packed {
        logic meta;
        logic stable;
        logic prev;
    } sync_state_t;

    typedef struct packed {
        logic [5:0]  slot_code;
        logic [7:0]  cfg_a;
        logic [7:0]  cfg_b;
        logic        basis;
        logic [7:0]  rdata;
        link_state_t link;
        logic [3:0]  div_cnt;
        logic        bclk;
        logic        fsync;
        logic        bclk_oe;
        logic        fsync_oe;
        logic [11:0] bitpos;
        logic [11:0] frame_len;
        logic        fs_last;
        logic        frame_seen;
        logic        slot_hit;
        logic        pll_en;
        logic        auto_derive;
        logic        family;
        logic [14:0] ref_khz;
        logic        ref_valid;
        logic        cfg_err;
        logic [11:0] ratio;
    } core_state_t;

endpackage

// ---- link_pin_sync.sv ----
module link_pin_sync (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic ce_i,
    // Pin from the link
    input  wire logic pin_i,
    // Synchronised view
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    import audio_port_pkg::*;

    sync_state_t st_ff;
    sync_state_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        if (ce_i)
        begin
            nxt_st.meta   = pin_i;
            nxt_st.stable = st_ff.meta;
            nxt_st.prev   = st_ff.stable;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    // Only the second and third stages are looked at
    assign level_o = st_ff.stable;
    assign rise_o  = ce_i && st_ff.stable && !st_ff.prev;
    assign fall_o  = ce_i && !st_ff.stable && st_ff.prev;
endmodule

// ---- audio_port_master_clock_config.sv ----
// What this block does
// - Channel four slot code is six bits, bits 5..0, reset value 3.
// - Codes 0-31 pick slot N or left slot N; 32-63 slot N or right slot N-32.
// - Role bit zero: slave, bit clock and frame sync are inputs.
// - Role bit one: master, device generates bit clock and frame sync.
// - Automatic clocking bit zero derives dividers and PLL; one disables derivation.
// - Under automatic clocking, PLL-off bit one disables the PLL.
// - In master, gating bit forces bit clock and frame sync to stop.
// - In master, family bit picks 48 kHz or 44.1 kHz rate family.
// - Three-bit reference frequency code, reset 2, maps to eight MHz values.
// - Four-bit frame rate code, reset 4; codes 9-15 reserved.
// - Four-bit bit clocks per frame code, reset 8; codes 13-15 reserved.
// - Basis bit picks frequency code or frame-rate multiple as reference.
//
// The strobed register port was chosen for this implementation.
`include "audio_port_cfg.svh"

module audio_port_master_clock_config (
    // Clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ce_i,
    // Register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    // Frame format from the serial port logic
    input  wire logic        fmt_two_chan_i,
    // Bit clock pin
    input  wire logic        bclk_pin_i,
    output logic             bclk_o,
    output logic             bclk_oe_o,
    // Frame sync pin
    input  wire logic        fsync_pin_i,
    output logic             fsync_o,
    output logic             fsync_oe_o,
    // Clocking and slot results
    output logic             chan_four_slot_o,
    output logic             pll_enable_o,
    output logic             auto_derive_o,
    output logic             rate_family_select_o,
    output logic      [14:0] ref_freq_khz_o,
    output logic             ref_freq_valid_o,
    output logic      [3:0]  programmed_frame_rate_o,
    output logic      [11:0] bitclock_per_frame_o,
    output logic             cfg_error_o,
    output audio_port_pkg::link_state_t link_state_o
);
    import audio_port_pkg::*;

    localparam logic [3:0] HALF_LAST = 4'(`BCLK_HALF_CYC - 1);

    localparam core_state_t RST = '{
        slot_code:   `CHAN_FOUR_SLOT_CODE_RST,
        cfg_a:       `CFG_A_RST,
        cfg_b:       `CFG_B_RST,
        basis:       `CLK_BASIS_RST,
        rdata:       8'h00,
        link:        LINK_SLAVE,
        div_cnt:     4'h0,
        bclk:        1'b0,
        fsync:       1'b0,
        bclk_oe:     1'b0,
        fsync_oe:    1'b0,
        bitpos:      12'h000,
        frame_len:   12'h100,
        fs_last:     1'b0,
        frame_seen:  1'b0,
        slot_hit:    1'b0,
        pll_en:      1'b1,
        auto_derive: 1'b1,
        family:      1'b0,
        ref_khz:     15'h32C8,
        ref_valid:   1'b0,
        cfg_err:     1'b0,
        ratio:       12'h100
    };

    core_state_t st_ff;
    core_state_t nxt_st;

    logic bclk_lvl;
    logic bclk_rise;
    logic fsync_lvl;

    link_pin_sync bclk_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .pin_i     (bclk_pin_i),
        .level_o   (bclk_lvl),
        .rise_o    (bclk_rise),
        .fall_o    ()
    );

    link_pin_sync fsync_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .pin_i     (fsync_pin_i),
        .level_o   (fsync_lvl),
        .rise_o    (),
        .fall_o    ()
    );

    function automatic logic [11:0] ratio_of(input logic [3:0] code);
        logic [11:0] r;
        unique case (code)
            4'h0:    r = 12'h010;
            4'h1:    r = 12'h018;
            4'h2:    r = 12'h020;
            4'h3:    r = 12'h030;
            4'h4:    r = 12'h040;
            4'h5:    r = 12'h060;
            4'h6:    r = 12'h080;
            4'h7:    r = 12'h0C0;
            4'h8:    r = 12'h100;
            4'h9:    r = 12'h180;
            4'hA:    r = 12'h200;
            4'hB:    r = 12'h400;
            4'hC:    r = 12'h800;
            default: r = 12'h100;
        endcase
        return r;
    endfunction

    function automatic logic [14:0] ref_khz_of(input logic [2:0] code);
        logic [14:0] k;
        unique case (code)
            3'h0: k = 15'h2EE0;
            3'h1: k = 15'h3000;
            3'h2: k = 15'h32C8;
            3'h3: k = 15'h3E80;
            3'h4: k = 15'h4B00;
            3'h5: k = 15'h4CE0;
            3'h6: k = 15'h5DC0;
            3'h7: k = 15'h6000;
        endcase
        return k;
    endfunction

    // Slots are 32 bit clocks wide; two-channel framing splits the frame in halves
    function automatic logic slot_match(input logic [11:0] pos, input logic [11:0] len,
                                        input logic [5:0] code, input logic two_chan);
        logic [11:0] half;
        logic        right;
        logic [11:0] rel;
        half  = {1'b0, len[11:1]};
        right = (pos >= half);
        rel   = right ? pos - half : pos;
        if (two_chan)
            return (right == code[5]) && (rel[10:5] == {1'b0, code[4:0]});
        return pos[10:5] == code;
    endfunction

    logic        bus_role_select;
    logic        master_clock_gating;
    logic        auto_pll_off;
    logic        rate_family_select;
    logic        reference_freq_basis;
    logic [2:0]  reference_freq_code;
    logic [3:0]  programmed_frame_rate;
    logic [3:0]  bitclock_per_frame_code;

    assign bus_role_select         = st_ff.cfg_a[`ROLE_BIT];
    assign master_clock_gating     = st_ff.cfg_a[`GATE_BIT];
    assign auto_pll_off            = st_ff.cfg_a[`PLL_OFF_BIT];
    assign rate_family_select      = st_ff.cfg_a[`FAMILY_BIT];
    assign reference_freq_basis    = st_ff.basis;
    assign reference_freq_code     = st_ff.cfg_a[`REF_CODE_MSB:`REF_CODE_LSB];
    assign programmed_frame_rate   = st_ff.cfg_b[`RATE_MSB:`RATE_LSB];
    assign bitclock_per_frame_code = st_ff.cfg_b[`RATIO_MSB:`RATIO_LSB];

    always_comb
    begin
        logic        auto_on;
        logic        slave_auto;
        logic        ratio_bad;
        logic        fs_start;
        logic [11:0] len;
        auto_on    = !st_ff.cfg_a[`AUTO_BIT];
        slave_auto = !bus_role_select && auto_on;
        ratio_bad  = bitclock_per_frame_code > `RATIO_CODE_MAX;
        fs_start   = 1'b0;
        len        = 12'h000;
        nxt_st     = st_ff;
        if (ce_i)
        begin
            nxt_st.rdata = 8'h00;
            if (reg_wr_i)
            begin
                unique case (reg_addr_i)
                    `CHAN_FOUR_SLOT_CODE_OFS:  nxt_st.slot_code = reg_wdata_i[5:0];
                    `CFG_A_OFS:     nxt_st.cfg_a = reg_wdata_i;
                    `CFG_B_OFS:     nxt_st.cfg_b = reg_wdata_i;
                    `CLK_BASIS_OFS: nxt_st.basis = reg_wdata_i[`BASIS_BIT];
                    default:        nxt_st.rdata = 8'h00;
                endcase
            end
            if (reg_rd_i)
            begin
                unique case (reg_addr_i)
                    `CHAN_FOUR_SLOT_CODE_OFS:    nxt_st.rdata = {2'b00, st_ff.slot_code};
                    `CFG_A_OFS:       nxt_st.rdata = st_ff.cfg_a;
                    `CFG_B_OFS:       nxt_st.rdata = st_ff.cfg_b;
                    `CLK_BASIS_OFS:   nxt_st.rdata = 8'(st_ff.basis) << `BASIS_BIT;
                    `PORT_STATUS_OFS: nxt_st.rdata = {4'h0, st_ff.frame_seen, st_ff.cfg_err,
                                                      st_ff.link == LINK_IDLE,
                                                      st_ff.link == LINK_MASTER};
                    default:          nxt_st.rdata = 8'h00;
                endcase
            end
            // Derived clocking decisions
            nxt_st.auto_derive = auto_on;
            nxt_st.pll_en      = auto_on && !auto_pll_off;
            nxt_st.family      = bus_role_select && rate_family_select;
            nxt_st.ref_khz     = ref_khz_of(reference_freq_code);
            nxt_st.ref_valid   = bus_role_select && auto_on && !reference_freq_basis;
            nxt_st.ratio       = ratio_of(bitclock_per_frame_code);
            // Reserved rate or ratio codes matter only where the fields are used
            nxt_st.cfg_err     = !slave_auto && (ratio_bad ||
                                 programmed_frame_rate > `RATE_CODE_MAX);
            len = st_ff.ratio;
            unique case (st_ff.link)
                LINK_IDLE:
                begin
                    // Park one bit before the frame so the restart opens a frame
                    nxt_st.div_cnt   = 4'h0;
                    nxt_st.bitpos    = len - 12'h001;
                    nxt_st.frame_len = len;
                    nxt_st.slot_hit  = 1'b0;
                end
                LINK_MASTER:
                begin
                    nxt_st.frame_len = len;
                    if (st_ff.div_cnt == HALF_LAST)
                    begin
                        nxt_st.div_cnt = 4'h0;
                        nxt_st.bclk    = !st_ff.bclk;
                        if (st_ff.bclk)
                        begin
                            nxt_st.bitpos   = (st_ff.bitpos >= len - 12'h001) ? 12'h000
                                              : st_ff.bitpos + 12'h001;
                            nxt_st.fsync    = nxt_st.bitpos == 12'h000;
                            nxt_st.slot_hit = slot_match(nxt_st.bitpos, len,
                                                         st_ff.slot_code, fmt_two_chan_i);
                        end
                    end
                    else
                        nxt_st.div_cnt = st_ff.div_cnt + 4'h1;
                end
                LINK_SLAVE:
                begin
                    if (bclk_rise)
                    begin
                        fs_start       = fsync_lvl && !st_ff.fs_last;
                        nxt_st.fs_last = fsync_lvl;
                        if (fs_start)
                        begin
                            nxt_st.frame_len  = st_ff.bitpos + 12'h001;
                            nxt_st.bitpos     = 12'h000;
                            nxt_st.frame_seen = 1'b1;
                        end
                        else if (st_ff.bitpos != 12'hFFF)
                            nxt_st.bitpos = st_ff.bitpos + 12'h001;
                        // Slave auto clocking ignores the ratio field and uses the measured frame
                        nxt_st.slot_hit = slot_match(nxt_st.bitpos,
                                                     slave_auto ? nxt_st.frame_len : len,
                                                     st_ff.slot_code, fmt_two_chan_i);
                    end
                end
                default:
                    nxt_st.link = LINK_IDLE;
            endcase
            if (!bus_role_select)
                nxt_st.link = LINK_SLAVE;
            else if (master_clock_gating || ratio_bad)
                nxt_st.link = LINK_IDLE;
            else if (st_ff.link != LINK_MASTER)
                nxt_st.link = LINK_IDLE;
            if (bus_role_select && !master_clock_gating && !ratio_bad &&
                st_ff.link == LINK_IDLE)
                nxt_st.link = LINK_MASTER;
            if (nxt_st.link == LINK_SLAVE && st_ff.link != LINK_SLAVE)
            begin
                nxt_st.frame_seen = 1'b0;
                nxt_st.fs_last    = 1'b1;
            end
            // Pins stay driven low while gated so the far end sees no stray edge
            if (nxt_st.link != LINK_MASTER)
            begin
                nxt_st.bclk  = 1'b0;
                nxt_st.fsync = 1'b0;
            end
            nxt_st.bclk_oe  = nxt_st.link != LINK_SLAVE;
            nxt_st.fsync_oe = nxt_st.link != LINK_SLAVE;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            st_ff <= RST;
        else
            st_ff <= nxt_st;
    end

    assign reg_rdata_o             = st_ff.rdata;
    assign bclk_o                  = st_ff.bclk;
    assign bclk_oe_o               = st_ff.bclk_oe;
    assign fsync_o                 = st_ff.fsync;
    assign fsync_oe_o              = st_ff.fsync_oe;
    assign chan_four_slot_o        = st_ff.slot_hit;
    assign pll_enable_o            = st_ff.pll_en;
    assign auto_derive_o           = st_ff.auto_derive;
    assign rate_family_select_o    = st_ff.family;
    assign ref_freq_khz_o          = st_ff.ref_khz;
    assign ref_freq_valid_o        = st_ff.ref_valid;
    assign programmed_frame_rate_o = programmed_frame_rate;
    assign bitclock_per_frame_o    = st_ff.ratio;
    assign cfg_error_o             = st_ff.cfg_err;
    assign link_state_o            = st_ff.link;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence bclk_high_run;
        $rose(st_ff.bclk) ##0 (ce_i && st_ff.link == LINK_MASTER) [*8];
    endsequence

    sequence master_entry;
        $past(st_ff.link) == LINK_IDLE ##0 st_ff.link == LINK_MASTER;
    endsequence

    slot_reset_value_a:
        assert property ($past(sys_rst_i) |-> st_ff.slot_code == 6'h03)
        else $error("slot code not 3 after reset");
    slot_upper_zero_a:
        assert property (ce_i && reg_rd_i && reg_addr_i == `CHAN_FOUR_SLOT_CODE_OFS
                         |=> reg_rdata_o[7:6] == 2'b00 && reg_rdata_o[5:0] == $past(st_ff.slot_code))
        else $error("slot register read wrong");
    slave_no_drive_a:
        assert property (st_ff.link == LINK_SLAVE |-> !bclk_oe_o && !fsync_oe_o)
        else $error("slave drives a link pin");
    master_drive_a:
        assert property (st_ff.link == LINK_MASTER |-> bclk_oe_o && fsync_oe_o)
        else $error("master not driving link pins");
    bclk_half_period_a:
        assert property (bclk_high_run |=> !st_ff.bclk)
        else $error("bit clock high phase wrong length");
    fsync_at_frame_a:
        assert property ($rose(st_ff.fsync) |-> st_ff.bitpos == 12'h000)
        else $error("frame sync away from bit zero");
    gate_quiet_a:
        assert property (ce_i && bus_role_select && master_clock_gating
                         |=> !bclk_o && !fsync_o && st_ff.link == LINK_IDLE)
        else $error("gated outputs still toggling");
    resume_boundary_a:
        assert property (master_entry |-> st_ff.bitpos == st_ff.frame_len - 12'h001 && !fsync_o)
        else $error("restart not at frame boundary");
    pll_enable_a:
        assert property (ce_i && st_ff.cfg_a[6:5] == 2'b00 |=> pll_enable_o)
        else $error("pll not enabled under auto clocking");
    ref_freq_top_a:
        assert property (ce_i && reference_freq_code == 3'h7 |=> ref_freq_khz_o == 15'h6000)
        else $error("reference code 7 not 24576 kHz");
    ratio_reserved_a:
        assert property (ce_i && bus_role_select && bitclock_per_frame_code > 4'hC
                         |=> cfg_error_o && st_ff.link == LINK_IDLE)
        else $error("reserved ratio not flagged");
endmodule

// ---- audio_host_model.sv ----
module audio_host_model (
    // Run control
    input  wire logic        run_i,
    input  wire logic [11:0] frame_bits_i,
    // Link pins driven by the host, and its bit index
    output logic             bclk_o,
    output logic             fsync_o,
    output int               bit_idx_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        bclk_o = 1'b0;
        fsync_o = 1'b0;
        bit_idx_o = 1;
        // Odd offset keeps the link out of phase with the system clock
        #3;
        forever
        begin
            // Bit clock stands still between bursts
            if (!run_i)
                @(posedge run_i);
            fsync_o = (bit_idx_o == 0);
            #32 bclk_o = 1'b1;
            #32 bclk_o = 1'b0;
            bit_idx_o = (bit_idx_o + 1) % frame_bits_i;
        end
    end
endmodule

// ---- tb.sv ----
`include "audio_port_cfg.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import audio_port_pkg::*;

    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        ce_i = 1'b1;
    logic        fmt_two_chan_i = 1'b0;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic [7:0]  reg_rdata_o;
    logic        bclk_o, bclk_oe_o, fsync_o, fsync_oe_o, chan_four_slot_o;
    logic        pll_enable_o, auto_derive_o, rate_family_select_o, ref_freq_valid_o;
    logic [14:0] ref_freq_khz_o;
    logic [3:0]  programmed_frame_rate_o;
    logic [11:0] bitclock_per_frame_o;
    logic        cfg_error_o;
    link_state_t link_state_o;
    logic        host_run = 1'b0;
    logic        h_bclk, h_fsync;
    int          h_idx;
    int          num_errors = 0;
    int          total_checks = 0;
    int          cycles = 0;
    logic        rd_pend = 1'b0;
    logic [7:0]  exp_q[$];
    logic [31:0] seed = 32'hB3E24EB6;
    int          ref_khz[8] = '{12000, 12288, 13000, 16000, 19200, 19680, 24000, 24576};
    int          ratio_tab[16] = '{16, 24, 32, 48, 64, 96, 128, 192, 256, 384, 512, 1024,
                                   2048, 256, 256, 256};

    always #2 clk_i = ~clk_i;

    audio_port_master_clock_config DUT (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .fmt_two_chan_i(fmt_two_chan_i),
        .bclk_pin_i(bclk_oe_o ? bclk_o : h_bclk), .bclk_o(bclk_o), .bclk_oe_o(bclk_oe_o),
        .fsync_pin_i(fsync_oe_o ? fsync_o : h_fsync), .fsync_o(fsync_o),
        .fsync_oe_o(fsync_oe_o), .chan_four_slot_o(chan_four_slot_o),
        .pll_enable_o(pll_enable_o), .auto_derive_o(auto_derive_o),
        .rate_family_select_o(rate_family_select_o), .ref_freq_khz_o(ref_freq_khz_o),
        .ref_freq_valid_o(ref_freq_valid_o), .programmed_frame_rate_o(programmed_frame_rate_o),
        .bitclock_per_frame_o(bitclock_per_frame_o), .cfg_error_o(cfg_error_o),
        .link_state_o(link_state_o)
    );

    audio_host_model host (
        .run_i(host_run), .frame_bits_i(12'd64), .bclk_o(h_bclk), .fsync_o(h_fsync),
        .bit_idx_o(h_idx)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic summarize();
        if (num_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // Expected read data goes in the queue; the monitor pops it one cycle later
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    always @(posedge clk_i)
    begin
        if (rd_pend)
            check("reg_rdata_o", {8'h00, reg_rdata_o}, {8'h00, exp_q.pop_front()});
        rd_pend <= reg_rd_i;
    end

    // Ceiling sits well above the few thousand cycles the sequence needs
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            num_errors++;
            summarize();
        end
    end

    initial
    begin
        int   j, n, m, k;
        logic prev, hi;
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(`CFG_A_OFS, `CFG_A_RST);
        rd(`CFG_B_OFS, `CFG_B_RST);
        rd(`CHAN_FOUR_SLOT_CODE_OFS, 8'h03);
        rd(8'h55, 8'h00);
        settle(1);
        check("ref_freq_khz_o", 16'(ref_freq_khz_o), 16'd13000);
        check("bitclock_per_frame_o", 16'(bitclock_per_frame_o), 16'd256);
        check("programmed_frame_rate_o", 16'(programmed_frame_rate_o), 16'd4);
        wr(`CHAN_FOUR_SLOT_CODE_OFS, 8'hFF);
        rd(`CHAN_FOUR_SLOT_CODE_OFS, 8'h3F);
        repeat (6)
        begin
            seed = xs(seed);
            wr(`CHAN_FOUR_SLOT_CODE_OFS, seed[7:0]);
            rd(`CHAN_FOUR_SLOT_CODE_OFS, {2'b00, seed[5:0]});
        end
        for (j = 0; j < 4; j++)
        begin
            wr(`CFG_A_OFS, {1'b0, j[1:0], 5'h0A});
            settle(3);
            check("auto_derive_o", 16'(auto_derive_o), 16'(!j[1]));
            check("pll_enable_o", 16'(pll_enable_o), 16'(!j[1] && !j[0]));
            check("rate_family_select_o", 16'(rate_family_select_o), 16'd0);
            check("bclk_oe_o", 16'(bclk_oe_o), 16'd0);
        end
        for (j = 0; j < 8; j++)
        begin
            wr(`CFG_A_OFS, {4'h9, j[0], j[2:0]});
            settle(3);
            check("ref_freq_khz_o", 16'(ref_freq_khz_o), 16'(ref_khz[j]));
            check("ref_freq_valid_o", 16'(ref_freq_valid_o), 16'd1);
            check("rate_family_select_o", 16'(rate_family_select_o), 16'(j[0]));
        end
        wr(`CLK_BASIS_OFS, 8'h40);
        settle(3);
        check("ref_freq_valid_o", 16'(ref_freq_valid_o), 16'd0);
        rd(`CLK_BASIS_OFS, 8'h40);
        wr(`CLK_BASIS_OFS, 8'h00);
        for (j = 0; j < 16; j++)
        begin
            wr(`CFG_B_OFS, {j[3:0], j[3:0]});
            settle(3);
            check("bitclock_per_frame_o", 16'(bitclock_per_frame_o), 16'(ratio_tab[j]));
            check("cfg_error_o", 16'(cfg_error_o), 16'(j > 8));
            check("programmed_frame_rate_o", 16'(programmed_frame_rate_o), 16'(j));
        end
        // Ratio 16 keeps a frame at 256 system cycles
        wr(`CFG_B_OFS, 8'h40);
        wr(`CFG_A_OFS, 8'h80);
        settle(4);
        check("bclk_oe_o", 16'(bclk_oe_o), 16'd1);
        check("fsync_oe_o", 16'(fsync_oe_o), 16'd1);
        check("link_state_o", 16'(link_state_o), 16'(LINK_MASTER));
        n = 0;
        m = 0;
        prev = bclk_o;
        repeat (1024)
        begin
            settle(1);
            n += (bclk_o !== prev);
            prev = bclk_o;
            m += (fsync_o === 1'b1);
        end
        check("bclk_o toggles", 16'(n), 16'd128);
        check("fsync_o high cycles", 16'(m), 16'd64);
        // A low enable must freeze the running bit clock mid-frame
        @(posedge clk_i);
        ce_i <= 1'b0;
        settle(2);
        hi = bclk_o;
        prev = fsync_o;
        settle(20);
        check("bclk_o frozen", 16'(bclk_o), 16'(hi));
        check("fsync_o frozen", 16'(fsync_o), 16'(prev));
        @(posedge clk_i);
        ce_i <= 1'b1;
        wr(`CFG_A_OFS, 8'h90);
        settle(2);
        check("link_state_o", 16'(link_state_o), 16'(LINK_IDLE));
        n = 0;
        repeat (64)
        begin
            settle(1);
            n += (bclk_o !== 1'b0) || (fsync_o !== 1'b0);
        end
        check("gated cycles active", 16'(n), 16'd0);
        wr(`CFG_A_OFS, 8'h80);
        k = 0;
        hi = 1'b0;
        while (k < 40 && !(hi && bclk_o === 1'b0))
        begin
            settle(1);
            hi |= (bclk_o === 1'b1);
            k++;
        end
        check("fsync_o at restart", 16'(fsync_o), 16'd1);
        wr(`CFG_A_OFS, 8'h02);
        settle(4);
        check("link_state_o", 16'(link_state_o), 16'(LINK_SLAVE));
        check("fsync_oe_o", 16'(fsync_oe_o), 16'd0);
        // TDM slot 1 and right-half slot 0 both cover bits 32 to 63
        for (j = 0; j < 2; j++)
        begin
            @(posedge clk_i);
            fmt_two_chan_i <= j[0];
            wr(`CHAN_FOUR_SLOT_CODE_OFS, j[0] ? 8'h20 : 8'h01);
            host_run <= 1'b1;
            repeat (128) @(posedge h_bclk);
            repeat (64)
            begin
                @(posedge h_bclk);
                #20;
                check("chan_four_slot_o", 16'(chan_four_slot_o), 16'(h_idx / 32 == 1));
            end
            host_run <= 1'b0;
        end
        // Slave with frames seen, legal codes: only the frame-seen flag is up
        rd(`PORT_STATUS_OFS, 8'h08);
        settle(2);
        summarize();
    end
endmodule
